//--- common/jbs_defs.svh
// Purpose: Offsets, opcodes, field positions and timing counts
// Assumes: 25 MHz core clock
// Notes:   Definitions only
`ifndef JBS_DEFS_SVH
`define JBS_DEFS_SVH
// I/O offsets
`define JBS_ADDR_DBG_CHAN   6'h31
`define JBS_ADDR_MCU_CTRL   6'h35
`define JBS_DIRTY_BIT       7
`define JBS_TPD_BIT         7
`define JBS_RST_BYTE        8'h00
// Instruction opcodes
`define JBS_IR_EXTEST       4'h0
`define JBS_IR_IDCODE       4'h1
`define JBS_IR_SAMPLE       4'h2
`define JBS_IR_DBG_CHAN     4'h8
`define JBS_IR_TEST_RESET   4'hC
`define JBS_IR_BYPASS       4'hF
`define JBS_IR_CAPTURE      4'h1
// Identification field positions
`define JBS_ID_VER_LSB      28
`define JBS_ID_PART_LSB     12
`define JBS_ID_MFR_LSB      1
// Debug channel update bits
`define JBS_DBG_CLR_BIT     0
`define JBS_DBG_ACC_BIT     1
// Timing
`define JBS_CLK_MHZ         25
`define JBS_TPD_WINDOW      3'h4
`define JBS_TOUT_SHORT_US   4
`define JBS_TOUT_LONG_US    64
`define JBS_TOUT_SHORT_CYC  (`JBS_TOUT_SHORT_US * `JBS_CLK_MHZ)
`define JBS_TOUT_LONG_CYC   (`JBS_TOUT_LONG_US * `JBS_CLK_MHZ)
`define JBS_TOUT_CNT_W      12
`endif

//--- common/jbs_pkg.sv
// Purpose: Shared types of the test port data-register block
// Assumes: Nothing
// Notes:   Constants live in jbs_defs.svh
`default_nettype none
package jbs_pkg;
    // Test access controller states, one-hot
    typedef enum logic [15:0] {
        TS_TLR  = 16'h0001, TS_IDLE = 16'h0002, TS_SELD = 16'h0004,
        TS_CAPD = 16'h0008, TS_SHD  = 16'h0010, TS_EX1D = 16'h0020,
        TS_PSD  = 16'h0040, TS_EX2D = 16'h0080, TS_UPD  = 16'h0100,
        TS_SELI = 16'h0200, TS_CAPI = 16'h0400, TS_SHI  = 16'h0800,
        TS_EX1I = 16'h1000, TS_PSI  = 16'h2000, TS_EX2I = 16'h4000,
        TS_UPI  = 16'h8000
    } jbs_tap_e;
    // Selected data register, one-hot
    typedef enum logic [4:0] {
        DR_BYP = 5'h01, DR_ID = 5'h02, DR_RST = 5'h04,
        DR_DBG = 5'h08, DR_BSC = 5'h10
    } jbs_dr_e;
    // Controller phase strobes
    typedef struct packed {
        logic tlr;
        logic cap_dr;
        logic sh_dr;
        logic up_dr;
        logic cap_ir;
        logic sh_ir;
        logic up_ir;
    } jbs_tap_ctl_s;
    // CPU I/O request
    typedef struct packed {
        logic [5:0] addr;
        logic       we;
        logic       re;
        logic [7:0] wdata;
    } jbs_io_req_s;
endpackage
`default_nettype wire

//--- rtl/jbs_sync.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: d is asynchronous to clk
// Notes:   Output moves once stages two and three agree
`default_nettype none
module jbs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } jbs_sync_s;
    jbs_sync_s st_ff, nxt_st;   // Stages and filtered output

    // Shift, and move q only where stages two and three agree
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q  = (st_ff.s2 & st_ff.s3) | (st_ff.q & (st_ff.s2 | st_ff.s3));
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;
endmodule
`default_nettype wire

//--- rtl/jbs_tap.sv
// Purpose: Sixteen-state test access controller
// Assumes: tms sampled on rising tck
// Notes:   hold_tlr parks the controller while the port is disabled
`default_nettype none
module jbs_tap (
    // Link clock and reset
    input  wire logic                tck,
    input  wire logic                rst_n,
    // Control
    input  wire logic                tms,
    input  wire logic                hold_tlr,
    // Phase strobes
    output jbs_pkg::jbs_tap_ctl_s    ctl
);
    typedef struct packed {
        jbs_pkg::jbs_tap_e st;
    } jbs_tap_s;
    jbs_tap_s st_ff, nxt_st;   // Controller state

    // Next state; five high tms from any state lands in reset
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff.st)
            jbs_pkg::TS_TLR:  nxt_st.st = tms ? jbs_pkg::TS_TLR  : jbs_pkg::TS_IDLE;
            jbs_pkg::TS_IDLE: nxt_st.st = tms ? jbs_pkg::TS_SELD : jbs_pkg::TS_IDLE;
            jbs_pkg::TS_SELD: nxt_st.st = tms ? jbs_pkg::TS_SELI : jbs_pkg::TS_CAPD;
            jbs_pkg::TS_CAPD: nxt_st.st = tms ? jbs_pkg::TS_EX1D : jbs_pkg::TS_SHD;
            jbs_pkg::TS_SHD:  nxt_st.st = tms ? jbs_pkg::TS_EX1D : jbs_pkg::TS_SHD;
            jbs_pkg::TS_EX1D: nxt_st.st = tms ? jbs_pkg::TS_UPD  : jbs_pkg::TS_PSD;
            jbs_pkg::TS_PSD:  nxt_st.st = tms ? jbs_pkg::TS_EX2D : jbs_pkg::TS_PSD;
            jbs_pkg::TS_EX2D: nxt_st.st = tms ? jbs_pkg::TS_UPD  : jbs_pkg::TS_SHD;
            jbs_pkg::TS_UPD:  nxt_st.st = tms ? jbs_pkg::TS_SELD : jbs_pkg::TS_IDLE;
            jbs_pkg::TS_SELI: nxt_st.st = tms ? jbs_pkg::TS_TLR  : jbs_pkg::TS_CAPI;
            jbs_pkg::TS_CAPI: nxt_st.st = tms ? jbs_pkg::TS_EX1I : jbs_pkg::TS_SHI;
            jbs_pkg::TS_SHI:  nxt_st.st = tms ? jbs_pkg::TS_EX1I : jbs_pkg::TS_SHI;
            jbs_pkg::TS_EX1I: nxt_st.st = tms ? jbs_pkg::TS_UPI  : jbs_pkg::TS_PSI;
            jbs_pkg::TS_PSI:  nxt_st.st = tms ? jbs_pkg::TS_EX2I : jbs_pkg::TS_PSI;
            jbs_pkg::TS_EX2I: nxt_st.st = tms ? jbs_pkg::TS_UPI  : jbs_pkg::TS_SHI;
            jbs_pkg::TS_UPI:  nxt_st.st = tms ? jbs_pkg::TS_SELD : jbs_pkg::TS_IDLE;
            default:          nxt_st.st = jbs_pkg::TS_TLR;
        endcase
        // Disabled port stays in reset
        if (hold_tlr) begin
            nxt_st.st = jbs_pkg::TS_TLR;
        end
    end

    // State register
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_ff.st <= jbs_pkg::TS_TLR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Phase strobes
    assign ctl.tlr    = (st_ff.st == jbs_pkg::TS_TLR);
    assign ctl.cap_dr = (st_ff.st == jbs_pkg::TS_CAPD);
    assign ctl.sh_dr  = (st_ff.st == jbs_pkg::TS_SHD);
    assign ctl.up_dr  = (st_ff.st == jbs_pkg::TS_UPD);
    assign ctl.cap_ir = (st_ff.st == jbs_pkg::TS_CAPI);
    assign ctl.sh_ir  = (st_ff.st == jbs_pkg::TS_SHI);
    assign ctl.up_ir  = (st_ff.st == jbs_pkg::TS_UPI);
endmodule
`default_nettype wire

//--- rtl/jbs_top.sv
// Purpose: Test port data registers, debug channel and reset control
// Assumes: clk 25 MHz core clock; tck from the test controller
// Notes:   The whole link side runs on tck alone
`include "jbs_defs.svh"
`default_nettype none
module jbs_top #(
    parameter int          NPINS   = 8,
    parameter logic [3:0]  VERSION = 4'h0,      // First silicon revision
    parameter logic [15:0] PART    = 16'h0000,  // Arbitrary value
    parameter logic [10:0] MFR     = 11'h000    // Arbitrary value
) (
    // Core clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Test port
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    output logic                    tdo_o,
    output logic                    tdo_oe,
    // CPU I/O access
    input  wire jbs_pkg::jbs_io_req_s io_req,
    input  wire logic [7:0]         std_rdata,
    output logic                    std_sel,
    output logic [7:0]              io_rdata,
    // Fuses and lock bits
    input  wire logic               test_port_enable_fuse,
    input  wire logic               debug_enable_fuse,
    input  wire logic               lock_bit_one,
    input  wire logic               lock_bit_two,
    input  wire logic               clk_opt_fuse,
    // Fuse programming
    input  wire logic               fuse_prog_req,
    input  wire logic               chip_erase_done,
    output logic                    fuse_prog_grant,
    // Reset
    input  wire logic               ext_reset_n,
    output logic                    sys_reset,
    // Port pins
    input  wire logic [NPINS-1:0]   pin_i,
    input  wire logic [NPINS-1:0]   core_pin_out,
    input  wire logic [NPINS-1:0]   core_pin_oe,
    output logic      [NPINS-1:0]   pin_o,
    output logic      [NPINS-1:0]   pin_oe
);
    localparam int BSW = 3 * NPINS;  // In, data, control per pin
    localparam logic [`JBS_TOUT_CNT_W-1:0] TOUT_S =
        `JBS_TOUT_CNT_W'(`JBS_TOUT_SHORT_CYC);
    localparam logic [`JBS_TOUT_CNT_W-1:0] TOUT_L =
        `JBS_TOUT_CNT_W'(`JBS_TOUT_LONG_CYC);
    // Identification word
    localparam logic [31:0] ID_VAL =
        (32'(VERSION) << `JBS_ID_VER_LSB) |
        (32'(PART) << `JBS_ID_PART_LSB) |
        (32'(MFR) << `JBS_ID_MFR_LSB) | 32'h0000_0001;

    // Link-side state
    typedef struct packed {
        logic [BSW-1:0]   bs_sh;    // Boundary shift chain
        logic [NPINS-1:0] bs_ctl;   // Latched output control
        logic [NPINS-1:0] bs_dat;   // Latched output data
        logic [3:0]       ir_sh;    // Instruction shift stage
        logic [3:0]       ir;       // Active instruction
        logic             byp;      // Bypass stage
        logic [31:0]      id_sh;    // Identification shift
        logic [8:0]       dbg_sh;   // Debug channel shift
        logic             rst_bit;  // Reset data register
        logic             acc_en;   // Debugger channel access
        logic             clr_tgl;  // Dirty clear event toggle
    } jbs_link_s;

    // Core-side state
    typedef struct packed {
        logic [7:0]                dbg_byte;  // Channel byte
        logic                      dirty;     // Channel written flag
        logic                      tpd;       // Port disable bit
        logic                      tpd_val;   // Armed value
        logic [2:0]                tpd_win;   // Arm window
        logic [`JBS_TOUT_CNT_W-1:0] rst_cnt;  // Reset time-out
        logic                      erased;    // Chip erase seen
        logic                      clr_seen;  // Last clear toggle
        logic [7:0]                rdata;     // Read data
    } jbs_core_s;

    jbs_link_s            lk_ff, nxt_lk;  // Link registers
    jbs_core_s            cr_ff, nxt_cr;  // Core registers
    jbs_pkg::jbs_tap_ctl_s ctl;           // Controller strobes
    jbs_pkg::jbs_dr_e     dr;             // Selected data register
    logic [1:0]           to_lk;          // dirty, tpd into link
    logic [3:0]           to_cr;          // Link levels and reset pin into core
    logic                 port_active;    // Port enabled
    logic                 dbg_ok;         // Debug system allowed
    logic                 extest;         // Boundary test active
    logic                 held;           // Reset source present
    logic                 hit_dbg;        // Debug channel routed
    logic                 hit_mcu;        // Control register hit

    // Data register chosen by an instruction
    function automatic jbs_pkg::jbs_dr_e dr_of(input logic [3:0] ir,
                                               input logic ok);
        unique case (ir)
            `JBS_IR_EXTEST, `JBS_IR_SAMPLE: dr_of = jbs_pkg::DR_BSC;
            `JBS_IR_IDCODE:     dr_of = jbs_pkg::DR_ID;
            `JBS_IR_TEST_RESET: dr_of = jbs_pkg::DR_RST;
            `JBS_IR_DBG_CHAN:   dr_of = ok ? jbs_pkg::DR_DBG : jbs_pkg::DR_BYP;
            default:            dr_of = jbs_pkg::DR_BYP;
        endcase
    endfunction

    // Core levels into the link domain
    jbs_sync #(.W(2)) u_sync_lk (
        .clk   (tck),
        .rst_n (rst_n),
        .d     ({cr_ff.dirty, cr_ff.tpd}),
        .q     (to_lk)
    );

    // Link levels and the external reset pin into the core domain
    jbs_sync #(.W(4)) u_sync_cr (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({lk_ff.rst_bit, lk_ff.acc_en, lk_ff.clr_tgl, ~ext_reset_n}),
        .q     (to_cr)
    );

    // Port enable and debug permission
    assign port_active = test_port_enable_fuse & ~to_lk[0];
    assign dbg_ok      = debug_enable_fuse & ~lock_bit_one & ~lock_bit_two;

    // Controller, parked while the port is off
    jbs_tap u_tap (
        .tck      (tck),
        .rst_n    (rst_n),
        .tms      (tms),
        .hold_tlr (~port_active),
        .ctl      (ctl)
    );

    assign dr = dr_of(lk_ff.ir, dbg_ok);

    // Link next state; runs without the core clock
    always_comb begin
        nxt_lk = lk_ff;
        if (ctl.tlr) begin
            nxt_lk.ir      = `JBS_IR_IDCODE;
            nxt_lk.rst_bit = 1'b0;
            nxt_lk.acc_en  = 1'b0;
        end
        // Instruction path
        if (ctl.cap_ir) begin
            nxt_lk.ir_sh = `JBS_IR_CAPTURE;
        end
        if (ctl.sh_ir) begin
            nxt_lk.ir_sh = {tdi, lk_ff.ir_sh[3:1]};
        end
        if (ctl.up_ir) begin
            nxt_lk.ir = lk_ff.ir_sh;
        end
        // Capture into the selected register
        if (ctl.cap_dr) begin
            unique case (dr)
                jbs_pkg::DR_BYP: nxt_lk.byp    = 1'b0;
                jbs_pkg::DR_ID:  nxt_lk.id_sh  = ID_VAL;
                jbs_pkg::DR_DBG: nxt_lk.dbg_sh = {to_lk[1], cr_ff.dbg_byte};
                jbs_pkg::DR_BSC: begin
                    for (int i = 0; i < NPINS; i++) begin
                        nxt_lk.bs_sh[3*i] = pin_i[i];
                    end
                end
                default: nxt_lk.rst_bit = lk_ff.rst_bit;
            endcase
        end
        // Shift, least bit first out
        if (ctl.sh_dr) begin
            unique case (dr)
                jbs_pkg::DR_BYP: nxt_lk.byp    = tdi;
                jbs_pkg::DR_ID:  nxt_lk.id_sh  = {tdi, lk_ff.id_sh[31:1]};
                jbs_pkg::DR_RST: nxt_lk.rst_bit = tdi;
                jbs_pkg::DR_DBG: nxt_lk.dbg_sh = {tdi, lk_ff.dbg_sh[8:1]};
                jbs_pkg::DR_BSC: nxt_lk.bs_sh  = {tdi, lk_ff.bs_sh[BSW-1:1]};
                default:         nxt_lk.byp    = lk_ff.byp;
            endcase
        end
        // Update latches
        if (ctl.up_dr) begin
            if (dr == jbs_pkg::DR_BSC) begin
                for (int i = 0; i < NPINS; i++) begin
                    nxt_lk.bs_dat[i] = lk_ff.bs_sh[3*i+1];
                    nxt_lk.bs_ctl[i] = lk_ff.bs_sh[3*i+2];
                end
            end
            if (dr == jbs_pkg::DR_DBG) begin
                nxt_lk.acc_en = lk_ff.dbg_sh[`JBS_DBG_ACC_BIT];
                if (lk_ff.dbg_sh[`JBS_DBG_CLR_BIT]) begin
                    nxt_lk.clr_tgl = ~lk_ff.clr_tgl;
                end
            end
        end
    end

    // Link register
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            lk_ff    <= '0;
            lk_ff.ir <= `JBS_IR_IDCODE;
        end else begin
            lk_ff <= nxt_lk;
        end
    end

    // Serial output of the active path
    always_comb begin
        tdo_oe = port_active & (ctl.sh_ir | ctl.sh_dr);
        tdo_o  = lk_ff.byp;
        if (ctl.sh_ir) begin
            tdo_o = lk_ff.ir_sh[0];
        end else begin
            unique case (dr)
                jbs_pkg::DR_ID:  tdo_o = lk_ff.id_sh[0];
                jbs_pkg::DR_RST: tdo_o = lk_ff.rst_bit;
                jbs_pkg::DR_DBG: tdo_o = lk_ff.dbg_sh[0];
                jbs_pkg::DR_BSC: tdo_o = lk_ff.bs_sh[0];
                default:         tdo_o = lk_ff.byp;
            endcase
        end
    end

    // Core-side decode
    assign hit_dbg = (io_req.addr == `JBS_ADDR_DBG_CHAN)
                     & debug_enable_fuse & to_cr[2];
    assign hit_mcu = (io_req.addr == `JBS_ADDR_MCU_CTRL);
    assign std_sel = ~hit_dbg;
    assign held    = to_cr[3] | to_cr[0];

    // Core next state
    always_comb begin
        nxt_cr = cr_ff;
        // Debugger consumed the byte
        if (to_cr[1] != cr_ff.clr_seen) begin
            nxt_cr.clr_seen = to_cr[1];
            nxt_cr.dirty    = 1'b0;
        end
        // CPU write wins over a clear in the same cycle
        if (io_req.we && hit_dbg) begin
            nxt_cr.dbg_byte = io_req.wdata;
            nxt_cr.dirty    = 1'b1;
        end
        // Port disable bit changes on two matching writes
        if (cr_ff.tpd_win != 3'h0) begin
            nxt_cr.tpd_win = cr_ff.tpd_win - 3'h1;
        end
        if (io_req.we && hit_mcu) begin
            if (cr_ff.tpd_win != 3'h0
                && io_req.wdata[`JBS_TPD_BIT] == cr_ff.tpd_val) begin
                nxt_cr.tpd     = cr_ff.tpd_val;
                nxt_cr.tpd_win = 3'h0;
            end else begin
                nxt_cr.tpd_val = io_req.wdata[`JBS_TPD_BIT];
                nxt_cr.tpd_win = `JBS_TPD_WINDOW;
            end
        end
        // Read data
        if (io_req.re) begin
            if (hit_dbg) begin
                nxt_cr.rdata = {cr_ff.dirty, cr_ff.dbg_byte[6:0]};
            end else if (hit_mcu) begin
                nxt_cr.rdata = {cr_ff.tpd, std_rdata[6:0]};
            end else begin
                nxt_cr.rdata = std_rdata;
            end
        end
        // Reset hold and time-out after release
        if (held) begin
            nxt_cr.rst_cnt = clk_opt_fuse ? TOUT_L : TOUT_S;
        end else if (cr_ff.rst_cnt != '0) begin
            nxt_cr.rst_cnt = cr_ff.rst_cnt - `JBS_TOUT_CNT_W'(1);
        end
        // Erase reopens the debug fuse
        if (chip_erase_done) begin
            nxt_cr.erased = 1'b1;
        end
    end

    // Core register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cr_ff          <= '0;
            cr_ff.dbg_byte <= `JBS_RST_BYTE;
        end else begin
            cr_ff <= nxt_cr;
        end
    end

    assign io_rdata = cr_ff.rdata;

    // Debug fuse write needs no lock bits, or an erase first
    assign fuse_prog_grant = fuse_prog_req
        & (~(lock_bit_one | lock_bit_two) | cr_ff.erased);

    // Reset: register bit acts at once, then held and timed out
    assign sys_reset = lk_ff.rst_bit | held
                       | (cr_ff.rst_cnt != '0);

    // Pin drive
    assign extest = port_active & (lk_ff.ir == `JBS_IR_EXTEST);
    assign pin_o  = extest ? lk_ff.bs_dat : core_pin_out;
    assign pin_oe = extest ? lk_ff.bs_ctl
                  : (sys_reset ? '0 : core_pin_oe);
endmodule
`default_nettype wire

//--- sim/jbs_tester.sv
// Purpose: Test controller model on the four-wire port
// Assumes: 48 ns link period, clock runs only within frames
// Notes:   Drives mid-cycle, samples tdo at the rising edge
`default_nettype none
module jbs_tester (
    // Test port
    output logic     tck, tms, tdi,
    input  wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One link cycle
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #24 o = tdo;
        tck = 1'b1;
        #24 tck = 1'b0;
    endtask
    // Mode select high parks the controller
    task automatic park();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
    endtask
    // Scan from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic o;
        dout = '0;
        // Idle edges let synchronised core levels reach the link before capture
        #7 repeat (3) step(1'b0, 1'b1, o);
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule
`default_nettype wire

//--- sim/jbs_top_bench.sv
// Purpose: Self-checking bench of the data-register block
// Assumes: Short clock option, time-out 100 cycles
// Notes:   Tester model drives the link
`default_nettype none
module jbs_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0]  VER = 4'h1;     // Arbitrary value
    localparam logic [15:0] PRT = 16'h5A3C; // Arbitrary value
    localparam logic [10:0] MKR = 11'h2B7;  // Arbitrary value
    logic clk, rst_n, tck, tms, tdi, tdo_o, tdo_oe, std_sel, fuse_prog_grant, sys_reset;
    logic test_port_enable_fuse, debug_enable_fuse, lock_bit_one, lock_bit_two;
    logic fuse_prog_req, chip_erase_done, ext_reset_n;
    logic [7:0] std_rdata, io_rdata, pin_o, pin_oe;
    logic [31:0] got;
    jbs_pkg::jbs_io_req_s io_req;
    int failures, num_checks, oe_cnt, oe_base;
    always #20 clk = ~clk;
    // Count link edges at which the port drives its serial output
    always @(posedge tck) if (tdo_oe === 1'b1) oe_cnt++;
    jbs_top #(.VERSION(VER), .PART(PRT), .MFR(MKR)) jbs_top_i (.clk, .rst_n, .tck, .tms,
        .tdi, .tdo_o, .tdo_oe, .io_req, .std_rdata, .std_sel, .io_rdata,
        .test_port_enable_fuse, .debug_enable_fuse, .lock_bit_one, .lock_bit_two,
        .clk_opt_fuse(1'b0), .fuse_prog_req, .chip_erase_done, .fuse_prog_grant,
        .ext_reset_n, .sys_reset, .pin_i(8'h5A), .core_pin_out(8'hC3),
        .core_pin_oe(8'h0F), .pin_o, .pin_oe);
    jbs_tester jbs_tester_i (.tck, .tms, .tdi, .tdo(tdo_o));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One CPU access, then idle
    task automatic cyc(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
        @(posedge clk) io_req <= '{addr: a, we: w, re: r, wdata: d};
        @(posedge clk) io_req <= '0;
    endtask
    task automatic rd(input string nm, input logic [5:0] a, input logic [7:0] e);
        cyc(1'b0, 1'b1, a, 8'h00);
        #1 chk(nm, {24'h0, e}, {24'h0, io_rdata});
    endtask
    // Bounded wait for reset to end
    task automatic settle();
        for (int i = 0; i < 300 && sys_reset !== 1'b0; i++) @(posedge clk);
        chk("reset release", 0, {31'h0, sys_reset});
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {clk, rst_n, lock_bit_one, lock_bit_two, fuse_prog_req, chip_erase_done} = '0;
        {test_port_enable_fuse, debug_enable_fuse, ext_reset_n} = 3'h7;
        io_req = '0;
        std_rdata = 8'h3C;
        failures = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        jbs_tester_i.park();
        jbs_tester_i.scan(1'b0, 32, 32'h0, got);
        chk("idcode", {VER, PRT, MKR, 1'b1}, got);
        jbs_tester_i.scan(1'b1, 4, 32'hF, got);
        chk("ir capture", 32'h1, got);
        jbs_tester_i.scan(1'b0, 3, 32'h7, got);
        chk("bypass", 32'h6, got);
        jbs_tester_i.scan(1'b1, 4, 32'hC, got);
        jbs_tester_i.scan(1'b0, 1, 32'h1, got);
        chk("test reset", 1, {31'h0, sys_reset});
        chk("reset high-z", 0, {24'h0, pin_oe});
        jbs_tester_i.scan(1'b1, 4, 32'h2, got);
        jbs_tester_i.scan(1'b0, 24, 32'h00DB_6DB6, got);
        chk("sample", 32'h0004_1208, got);
        chk("sample pins", 32'hC3, {24'h0, pin_o});
        jbs_tester_i.scan(1'b1, 4, 32'h0, got);
        chk("extest pins", 32'h0000_FFFF, {16'h0, pin_oe, pin_o});
        jbs_tester_i.scan(1'b1, 4, 32'hC, got);
        jbs_tester_i.scan(1'b0, 1, 32'h0, got);
        repeat (50) @(posedge clk);
        #1 chk("time-out", 1, {31'h0, sys_reset});
        settle();
        ext_reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk("pin reset", 1, {31'h0, sys_reset});
        ext_reset_n <= 1'b1;
        settle();
        rd("std path", 6'h31, 8'h3C);
        jbs_tester_i.scan(1'b1, 4, 32'h8, got);
        jbs_tester_i.scan(1'b0, 9, 32'h2, got);
        repeat (6) @(posedge clk);
        cyc(1'b1, 1'b0, 6'h31, 8'hA5);
        rd("mailbox", 6'h31, 8'hA5);
        jbs_tester_i.scan(1'b0, 9, 32'h3, got);
        chk("debugger byte", 32'h1A5, got);
        repeat (6) @(posedge clk);
        rd("dirty clear", 6'h31, 8'h25);
        rd("unmapped", 6'h10, 8'h3C);
        debug_enable_fuse <= 1'b0;
        rd("fuse off", 6'h31, 8'h3C);
        @(posedge clk) {lock_bit_one, fuse_prog_req} <= 2'h3;
        @(posedge clk) #1 chk("locked grant", 0, {31'h0, fuse_prog_grant});
        chip_erase_done <= 1'b1;
        @(posedge clk) chip_erase_done <= 1'b0;
        @(posedge clk) #1 chk("erased grant", 1, {31'h0, fuse_prog_grant});
        test_port_enable_fuse <= 1'b0;
        oe_base = oe_cnt;
        jbs_tester_i.scan(1'b0, 8, 32'h0, got);
        chk("port off", 0, oe_cnt - oe_base);
        cyc(1'b1, 1'b0, 6'h35, 8'h80);
        cyc(1'b1, 1'b0, 6'h35, 8'h80);
        rd("disable bit", 6'h35, 8'hBC);
        close_out();
    end
endmodule
`default_nettype wire

//--- sim/jbs_top_sva.sv
// Purpose: Port checks of the data-register block
// Assumes: Core and link domains, both reset by rst_n
// Notes:   Bound at the foot
`default_nettype none
module jbs_top_sva (
    // Clocks, reset and ports watched
    input wire logic clk, rst_n, tck, tms, tdo_oe, std_sel, sys_reset, ext_reset_n,
    input wire jbs_pkg::jbs_io_req_s io_req,
    input wire logic [7:0] io_rdata,
    input wire logic debug_enable_fuse, test_port_enable_fuse, lock_bit_one, lock_bit_two,
    input wire logic fuse_prog_req, fuse_prog_grant
);
    logic [11:0] hi_ff;  // Length of the current reset pulse
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) hi_ff <= 12'h000;
        else hi_ff <= sys_reset ? hi_ff + 12'h001 : 12'h000;
    property p_route; @(posedge clk) disable iff (!rst_n)
        io_req.addr == 6'h31 && !debug_enable_fuse |-> std_sel; endproperty
    a_route: assert property (p_route) else $error("mailbox open without fuse");
    property p_mbox; @(posedge clk) disable iff (!rst_n)
        io_req.we && io_req.addr == 6'h31 && !std_sel ##2 io_req.re && io_req.addr == 6'h31
        && !std_sel |=> io_rdata == {1'b1, $past(io_req.wdata[6:0], 3)}; endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox read wrong");
    property p_grant; @(posedge clk) disable iff (!rst_n)
        !lock_bit_one && !lock_bit_two |-> fuse_prog_grant == fuse_prog_req; endproperty
    a_grant: assert property (p_grant) else $error("fuse grant wrong");
    property p_pin_rst; @(posedge clk) disable iff (!rst_n)
        !ext_reset_n [*6] |-> sys_reset; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset missed");
    property p_tout; @(posedge clk) disable iff (!rst_n)
        $fell(sys_reset) && $past(rst_n) |-> hi_ff >= 12'd100; endproperty
    a_tout: assert property (p_tout) else $error("reset time-out short");
    property p_port_off; @(posedge tck) disable iff (!rst_n)
        !test_port_enable_fuse [*2] |-> !tdo_oe; endproperty
    a_port_off: assert property (p_port_off) else $error("port active without fuse");
    property p_tlr; @(posedge tck) disable iff (!rst_n) tms [*5] |=> !tdo_oe; endproperty
    a_tlr: assert property (p_tlr) else $error("no reset after five highs");
    property p_shift; @(posedge tck) disable iff (!rst_n)
        $rose(tdo_oe) |-> !$past(tms); endproperty
    a_shift: assert property (p_shift) else $error("shift entered wrongly");
    c_mbox: cover property (@(posedge clk) io_req.we && !std_sel);
    c_rst: cover property (@(posedge clk) $rose(sys_reset));
    c_oe: cover property (@(posedge tck) $rose(tdo_oe));
endmodule
bind jbs_top jbs_top_sva jbs_top_sva_i (.clk, .rst_n, .tck, .tms, .tdo_oe, .std_sel,
    .sys_reset, .ext_reset_n, .io_req, .io_rdata, .debug_enable_fuse,
    .test_port_enable_fuse, .lock_bit_one, .lock_bit_two, .fuse_prog_req, .fuse_prog_grant);
`default_nettype wire
